// file: rtl/arp_params.svh
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH
// clock period of the shared clock, in ns
`define ARP_CLK_NS 4
// address and data widths of the port
`define ARP_ADDR_W 12
`define ARP_DATA_W 16
// stages of the pin synchroniser
`define ARP_SYNC_STAGES 2
// command space: index of the sequencer control word and its release bit
`define ARP_CMD_IDX_W 3
`define ARP_CMD_RELEASE_IDX 3'h4
`define ARP_CMD_RELEASE_BIT 4
// host timing, least times in ns, counts rounded up to whole cycles
`define ARP_TURN_NS 16
`define ARP_PULSE_NS 32
`define ARP_TURN_CYC ((`ARP_TURN_NS + `ARP_CLK_NS - 1) / `ARP_CLK_NS)
`define ARP_PULSE_CYC ((`ARP_PULSE_NS + `ARP_CLK_NS - 1) / `ARP_CLK_NS)
`endif

// file: rtl/arp_pkg.sv
`default_nettype none
package arp_pkg;
    // states of the host strobe sequencer
    typedef enum logic [2:0] {
        ARP_IDLE,
        ARP_SETUP,
        ARP_TURN,
        ARP_PULSE,
        ARP_RECOVER
    } arp_host_state_t;
    // one byte lane
    typedef logic [7:0] arp_byte_t;
endpackage
`default_nettype wire

// file: rtl/arp_if.sv
`default_nettype none
`include "arp_params.svh"
interface arp_if;
    // strobes, all active low except rw (high = read)
    logic cs_n;
    logic rw;
    logic oe_n;
    logic lower_byte_select_n;
    logic upper_byte_select_n;
    logic cmd_n;
    logic [`ARP_ADDR_W-1:0] addr;
    // data drivers of each end, enables low while driving, one per lane
    logic [`ARP_DATA_W-1:0] dq_dev;
    logic [1:0] dq_dev_oe_n;
    logic [`ARP_DATA_W-1:0] dq_host;
    logic [1:0] dq_host_oe_n;
    // resolved wire level, an idle lane pulls high
    logic [`ARP_DATA_W-1:0] dq;
    // lanes driven by both ends at once
    logic [1:0] contention;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            dq[i*8 +: 8] = (dq_dev_oe_n[i] ? 8'hFF : dq_dev[i*8 +: 8]) & (dq_host_oe_n[i] ? 8'hFF : dq_host[i*8 +: 8]);
            contention[i] = !dq_dev_oe_n[i] && !dq_host_oe_n[i];
        end
    end
    modport dev (
        input cs_n, rw, oe_n, lower_byte_select_n, upper_byte_select_n, cmd_n, addr, dq,
        output dq_dev, dq_dev_oe_n
    );
    modport host (
        output cs_n, rw, oe_n, lower_byte_select_n, upper_byte_select_n, cmd_n, addr, dq_host, dq_host_oe_n,
        input dq
    );
endinterface
`default_nettype wire

// file: rtl/arp_dev.sv
`default_nettype none
`include "arp_params.svh"
// Behaviour
// - host holds rw high through reads
// - store only when rw, cs or cmd, and a byte select low
// - host keeps strobes inactive during address change
// - rw low before cs: never drive that access
// - no output drive during any write
// - host waits for device release before driving
// - cmd low, cs high selects command space
// - host write pulse outlasts device bus release
// - zero to bit 4 at index 4 releases sequencer
module arp_dev #(
    parameter int AW = `ARP_ADDR_W,
    parameter int DW = `ARP_DATA_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // random port pins
    arp_if.dev port,
    // sequencer side
    output logic seq_release_o,
    output logic [DW-1:0] seq_ctrl_o
);
    localparam int SW = 6 + AW + DW; // width of the synchronised pin vector
    localparam int CW = `ARP_CMD_IDX_W;

    // pin synchroniser stages
    logic [SW-1:0] s1_r;
    logic [SW-1:0] s2_r;
    // synchronised pin fields
    logic cs_n;
    logic rw;
    logic oe_n;
    logic cmd_n;
    logic [1:0] lane_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] din;
    // decoded access
    logic mem_acc;
    logic cmd_acc;
    logic wr_en;
    logic rd_en;
    logic [DW-1:0] rd_word;
    logic [DW-1:0] cmd_word;
    // access state: a write strobe was seen in this access
    logic wr_seen_r;
    logic wr_seen_nxt;
    // output registers
    logic [DW-1:0] dq_r;
    logic [DW-1:0] dq_nxt;
    logic [1:0] dq_oe_n_r;
    logic [1:0] dq_oe_n_nxt;
    logic release_r;
    logic release_nxt;

    // two flops on every pin before any logic
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= {{6{1'b1}}, {(AW + DW){1'b0}}};
            s2_r <= {{6{1'b1}}, {(AW + DW){1'b0}}};
        end else begin
            s1_r <= {port.cs_n, port.rw, port.oe_n, port.cmd_n, port.upper_byte_select_n,
                     port.lower_byte_select_n, port.addr, port.dq};
            s2_r <= s1_r;
        end
    end

    // split the synchronised vector
    assign {cs_n, rw, oe_n, cmd_n, lane_n, addr, din} = s2_r;

    // access decode
    always_comb begin
        mem_acc = !cs_n && cmd_n;
        // cs and cmd both low is illegal and is ignored
        cmd_acc = !cmd_n && cs_n;
        // store only in the overlap of rw, select and a byte select
        wr_en = (mem_acc || cmd_acc) && !rw && (lane_n != 2'b11);
    end

    // write-seen flag: once rw is low inside an access, the access stays undriven
    always_comb begin
        if (!mem_acc && !cmd_acc) begin
            // access over
            wr_seen_nxt = 1'b0;
        end else if (!rw) begin
            // select fell with or after rw
            wr_seen_nxt = 1'b1;
        end else begin
            wr_seen_nxt = wr_seen_r;
        end
        // drive only in a read with output enable and no write seen
        rd_en = (mem_acc || cmd_acc) && rw && !oe_n && !wr_seen_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_seen_r <= 1'b0;
        end else begin
            wr_seen_r <= wr_seen_nxt;
        end
    end

    // per-lane storage, command space and read mux
    for (genvar g = 0; g < 2; g++) begin : g_lane
        // memory lane
        logic [7:0] mem_q [1 << AW];
        // command space lane
        logic [7:0] cmd_q [1 << CW];
        // lane write, gated by its own byte select
        always_ff @(posedge clk_i) begin
            if (wr_en && mem_acc && !lane_n[g]) begin
                mem_q[addr] <= din[g*8 +: 8];
            end
        end
        // command words reset to zero
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                for (int k = 0; k < (1 << CW); k++) begin
                    cmd_q[k] <= 8'h00;
                end
            end else if (wr_en && cmd_acc && !lane_n[g]) begin
                cmd_q[addr[CW-1:0]] <= din[g*8 +: 8];
            end
        end
        // read source by space
        assign rd_word[g*8 +: 8] = cmd_acc ? cmd_q[addr[CW-1:0]] : mem_q[addr];
        // sequencer control word
        assign cmd_word[g*8 +: 8] = cmd_q[`ARP_CMD_RELEASE_IDX];
    end

    // output drive and release pulse
    always_comb begin
        dq_nxt = rd_word;
        for (int i = 0; i < 2; i++) begin
            // each lane drives only under its own byte select
            dq_oe_n_nxt[i] = !(rd_en && !lane_n[i]);
        end
        // zero written to the release bit of the control word
        release_nxt = wr_en && cmd_acc && (addr[CW-1:0] == `ARP_CMD_RELEASE_IDX)
                      && !lane_n[0] && !din[`ARP_CMD_RELEASE_BIT];
    end

    // output registers, released after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dq_r <= 16'h0000;
            dq_oe_n_r <= 2'b11;
            release_r <= 1'b0;
            seq_ctrl_o <= 16'h0000;
        end else begin
            dq_r <= dq_nxt;
            dq_oe_n_r <= dq_oe_n_nxt;
            release_r <= release_nxt;
            seq_ctrl_o <= cmd_word;
        end
    end

    // pins and sequencer outputs
    assign port.dq_dev = dq_r;
    assign port.dq_dev_oe_n = dq_oe_n_r;
    assign seq_release_o = release_r;
endmodule // arp_dev
`default_nettype wire

// file: rtl/arp_host.sv
`default_nettype none
`include "arp_params.svh"
module arp_host #(
    parameter int AW = `ARP_ADDR_W,
    parameter int DW = `ARP_DATA_W,
    parameter int TURN_CYC = `ARP_TURN_CYC,
    parameter int PULSE_CYC = `ARP_PULSE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins toward the device
    arp_if.host port,
    // user request
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_cmd_i,
    input wire logic [AW-1:0] req_addr_i,
    input wire logic [DW-1:0] req_wdata_i,
    input wire logic [1:0] req_be_i,
    // user answer
    output logic ready_o,
    output logic done_o,
    output logic [DW-1:0] rdata_o
);
    // sequencer state and cycles left in the current phase
    arp_pkg::arp_host_state_t state_r;
    arp_pkg::arp_host_state_t state_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    // latched request kind and lanes
    logic wr_r;
    logic wr_nxt;
    logic cmd_r;
    logic cmd_nxt;
    logic [1:0] be_r;
    logic [1:0] be_nxt;
    // pin registers, all strobes active low except rw
    logic cs_n_r;
    logic cs_n_nxt;
    logic rw_r;
    logic rw_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic lb_n_r;
    logic lb_n_nxt;
    logic ub_n_r;
    logic ub_n_nxt;
    logic cmd_n_r;
    logic cmd_n_nxt;
    logic [AW-1:0] addr_r;
    logic [AW-1:0] addr_nxt;
    logic [DW-1:0] dout_r;
    logic [DW-1:0] dout_nxt;
    logic [1:0] dout_oe_n_r;
    logic [1:0] dout_oe_n_nxt;
    // user answer registers
    logic ready_r;
    logic ready_nxt;
    logic done_r;
    logic done_nxt;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;

    // strobe sequencer: setup, strobe pulse, then a recovery long enough for the device to let go
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        cmd_nxt = cmd_r;
        be_nxt = be_r;
        cs_n_nxt = cs_n_r;
        rw_nxt = rw_r;
        oe_n_nxt = oe_n_r;
        lb_n_nxt = lb_n_r;
        ub_n_nxt = ub_n_r;
        cmd_n_nxt = cmd_n_r;
        addr_nxt = addr_r;
        dout_nxt = dout_r;
        dout_oe_n_nxt = dout_oe_n_r;
        ready_nxt = ready_r;
        done_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (state_r)
            arp_pkg::ARP_IDLE: begin
                ready_nxt = 1'b1;
                if (req_i && ready_r) begin
                    // take the request; address moves while all strobes are inactive
                    wr_nxt = req_write_i;
                    cmd_nxt = req_cmd_i;
                    be_nxt = req_be_i;
                    addr_nxt = req_addr_i;
                    dout_nxt = req_wdata_i;
                    // the device was released during the last recovery, so drive now
                    dout_oe_n_nxt = req_write_i ? 2'b00 : 2'b11;
                    ready_nxt = 1'b0;
                    state_nxt = arp_pkg::ARP_SETUP;
                end
            end
            arp_pkg::ARP_SETUP: begin
                // open the strobe window; never both selects at once
                rw_nxt = !wr_r;
                cs_n_nxt = cmd_r;
                cmd_n_nxt = !cmd_r;
                lb_n_nxt = !be_r[0];
                ub_n_nxt = !be_r[1];
                // output enable stays high through writes
                oe_n_nxt = wr_r;
                cnt_nxt = 8'(PULSE_CYC - 1);
                state_nxt = arp_pkg::ARP_PULSE;
            end
            arp_pkg::ARP_PULSE: begin
                if (cnt_r == 8'h00) begin
                    // end of pulse: drop the selects, a read takes its data here
                    cs_n_nxt = 1'b1;
                    cmd_n_nxt = 1'b1;
                    if (wr_r) begin
                        rw_nxt = 1'b1;
                        lb_n_nxt = 1'b1;
                        ub_n_nxt = 1'b1;
                    end else begin
                        rdata_nxt = port.dq;
                    end
                    cnt_nxt = 8'(TURN_CYC - 1);
                    state_nxt = arp_pkg::ARP_RECOVER;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            arp_pkg::ARP_RECOVER: begin
                if (cnt_r == 8'h00) begin
                    // bus idle again, hand the answer back
                    rw_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    lb_n_nxt = 1'b1;
                    ub_n_nxt = 1'b1;
                    dout_oe_n_nxt = 2'b11;
                    done_nxt = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = arp_pkg::ARP_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            default: begin
                state_nxt = arp_pkg::ARP_IDLE;
            end
        endcase
    end

    // register the sequencer and the pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= arp_pkg::ARP_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            cmd_r <= 1'b0;
            be_r <= 2'h0;
            cs_n_r <= 1'b1;
            rw_r <= 1'b1;
            oe_n_r <= 1'b1;
            lb_n_r <= 1'b1;
            ub_n_r <= 1'b1;
            cmd_n_r <= 1'b1;
            addr_r <= '0;
            dout_r <= '0;
            dout_oe_n_r <= 2'b11;
            ready_r <= 1'b0;
            done_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            cmd_r <= cmd_nxt;
            be_r <= be_nxt;
            cs_n_r <= cs_n_nxt;
            rw_r <= rw_nxt;
            oe_n_r <= oe_n_nxt;
            lb_n_r <= lb_n_nxt;
            ub_n_r <= ub_n_nxt;
            cmd_n_r <= cmd_n_nxt;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            dout_oe_n_r <= dout_oe_n_nxt;
            ready_r <= ready_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // pins and answer straight from flops
    assign port.cs_n = cs_n_r;
    assign port.rw = rw_r;
    assign port.oe_n = oe_n_r;
    assign port.lower_byte_select_n = lb_n_r;
    assign port.upper_byte_select_n = ub_n_r;
    assign port.cmd_n = cmd_n_r;
    assign port.addr = addr_r;
    assign port.dq_host = dout_r;
    assign port.dq_host_oe_n = dout_oe_n_r;
    assign ready_o = ready_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
endmodule // arp_host
`default_nettype wire

// file: tb/arp_properties.sv
`default_nettype none
`include "arp_params.svh"
// watches the random port wires between the two ends
module arp_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // strobes and address
    input wire logic cs_n,
    input wire logic rw,
    input wire logic oe_n,
    input wire logic lower_byte_select_n,
    input wire logic upper_byte_select_n,
    input wire logic cmd_n,
    input wire logic [`ARP_ADDR_W-1:0] addr,
    // device drive enables and lane clash flags
    input wire logic [1:0] dq_dev_oe_n,
    input wire logic [1:0] contention
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_no_lane_clash: assert property (contention == 2'h0)
        else $error("both ends drive a lane");
    a_write_no_drive: assert property (!rw |-> dq_dev_oe_n == 2'h3)
        else $error("device drives during write");
    a_cmd_cs_apart: assert property (cmd_n || cs_n)
        else $error("command and chip select low together");
    a_low_lane_gate: assert property (!dq_dev_oe_n[0] |-> !lower_byte_select_n)
        else $error("lower lane driven while unselected");
    a_high_lane_gate: assert property (!dq_dev_oe_n[1] |-> !upper_byte_select_n)
        else $error("upper lane driven while unselected");
    a_drive_needs_oe: assert property (dq_dev_oe_n != 2'h3 |-> !oe_n && rw)
        else $error("drive without output enable in a read");
    a_addr_move_idle: assert property ($changed(addr) |-> rw || (cs_n && cmd_n)
        || (lower_byte_select_n && upper_byte_select_n)) else $error("address moved inside an access");
    a_late_cs_hiz: assert property ($fell(cs_n) && !rw |-> (dq_dev_oe_n == 2'h3) [*3])
        else $error("output left high impedance state");
    // main traffic kinds
    c_write: cover property (!rw && !cs_n);
    c_read: cover property (!cs_n && dq_dev_oe_n == 2'h0);
    c_cmd: cover property (!cmd_n && !rw);
endmodule // arp_properties
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`include "arp_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and user side of the host
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_i = 1'b0, req_write_i = 1'b0, req_cmd_i = 1'b0, rel_seen = 1'b0;
    logic [11:0] req_addr_i = 12'h000;
    logic [15:0] req_wdata_i = 16'h0000, rdata_o;
    logic [1:0] req_be_i = 2'h3;
    logic ready_o, done_o, seq_release_o;
    int bad_count = 0, check_count = 0, cyc = 0;
    arp_if bus_if ();
    arp_dev i_arp_dev (.clk_i, .rst_i, .port(bus_if.dev), .seq_release_o, .seq_ctrl_o());
    arp_host i_arp_host (.clk_i, .rst_i, .port(bus_if.host), .req_i, .req_write_i, .req_cmd_i, .req_addr_i,
        .req_wdata_i, .req_be_i, .ready_o, .done_o, .rdata_o);
    arp_properties i_arp_properties (.clk_i, .rst_i, .cs_n(bus_if.cs_n), .rw(bus_if.rw), .oe_n(bus_if.oe_n),
        .lower_byte_select_n(bus_if.lower_byte_select_n), .upper_byte_select_n(bus_if.upper_byte_select_n),
        .cmd_n(bus_if.cmd_n), .addr(bus_if.addr), .dq_dev_oe_n(bus_if.dq_dev_oe_n), .contention(bus_if.contention));
    // 250 MHz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // catches the release pulse and cuts a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (seq_release_o === 1'b1) rel_seen <= 1'b1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // expected word after a lane-selective write
    function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] be);
        return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one host transfer: hold the request until taken, then wait for done
    task automatic op(input logic w, c, input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        n = 0;
        @(negedge clk_i);
        {req_i, req_write_i, req_cmd_i, req_addr_i, req_wdata_i, req_be_i} = {1'b1, w, c, a, d, be};
        while (ready_o !== 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
        @(negedge clk_i) req_i = 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 400) bad_count++;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        logic [11:0] a;
        logic [15:0] d0, d1;
        logic [1:0] be;
        void'($urandom(71927));
        repeat (10) @(negedge clk_i);
        rst_i = 1'b0;
        // full word, then a lane-selective rewrite (no lane at all included), then read back
        for (int i = 0; i < 24; i++) begin
            a = 12'($urandom);
            d0 = 16'($urandom);
            d1 = 16'($urandom);
            be = 2'(i % 4);
            op(1'b1, 1'b0, a, d0, 2'h3);
            op(1'b1, 1'b0, a, d1, be);
            op(1'b0, 1'b0, a, 16'h0000, 2'h3);
            chk(rdata_o, merge(d0, d1, be));
        end
        // command word: a one in the release bit keeps the sequencer stopped
        op(1'b1, 1'b1, 12'h004, 16'h0010, 2'h3);
        repeat (20) @(negedge clk_i);
        chk(16'(rel_seen), 16'h0000);
        op(1'b1, 1'b1, 12'h004, 16'h0000, 2'h3);
        repeat (20) @(negedge clk_i);
        chk(16'(rel_seen), 16'h0001);
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
